/* File: shared/tbc_cfg.svh */
// constants for the 16-bit byte-access timer core: offsets, fields, reset values, tops
// assumes it is included by bare name from every file that needs a figure
`ifndef TBC_CFG_SVH
`define TBC_CFG_SVH
// register offsets on the 4-bit address port
`define TBC_A_CNT_LO 4'h0
`define TBC_A_CNT_HI 4'h1
`define TBC_A_MA_LO 4'h2
`define TBC_A_MA_HI 4'h3
`define TBC_A_MB_LO 4'h4
`define TBC_A_MB_HI 4'h5
`define TBC_A_SNAP_LO 4'h6
`define TBC_A_SNAP_HI 4'h7
`define TBC_A_CTL1 4'h8
`define TBC_A_CTL2 4'h9
`define TBC_A_FLAGS 4'ha
// field positions
`define TBC_CTL1_WM_LO 1:0
`define TBC_CTL2_WM_HI 4:3
`define TBC_CTL2_CS 2:0
`define TBC_FLAG_WRAP 0
// reset values
`define TBC_RST_BYTE 8'h00
`define TBC_RST_WORD 16'h0000
`define TBC_RST_MODE 4'h0
`define TBC_RST_SEL 3'h0
// counter figures
`define TBC_BOTTOM 16'h0000
`define TBC_MAX 16'hffff
`define TBC_STEP 16'h0001
`define TBC_TOP_8 16'h00ff
`define TBC_TOP_9 16'h01ff
`define TBC_TOP_10 16'h03ff
// tick source codes
`define TBC_CS_NONE 3'h0
`define TBC_CS_DIV1 3'h1
`define TBC_CS_DIV8 3'h2
`define TBC_CS_DIV64 3'h3
`define TBC_CS_DIV256 3'h4
`define TBC_CS_DIV1024 3'h5
`define TBC_CS_EXT_FALL 3'h6
`define TBC_CS_EXT_RISE 3'h7
// prescaler width and the all-ones masks of its four taps
`define TBC_PRESCALE_W 10
`define TBC_TAP_MASKS {10'h3ff, 10'h0ff, 10'h03f, 10'h007}
`define TBC_TAPS 4
`endif

/* File: shared/tbc_pkg.sv */
// types of the 16-bit byte-access timer core
// assumes nothing beyond a SystemVerilog compiler; nothing here is imported
package tbc_pkg;
  typedef logic [7:0] tbc_byte_t; // one bus byte
  typedef logic [15:0] tbc_word_t; // one timer word
  typedef logic [3:0] tbc_mode_t; // wave mode select code
  typedef logic [2:0] tbc_sel_t; // tick source select code
  // count direction, one-hot
  typedef enum logic [1:0] {
    tbc_dir_up = 2'b01,
    tbc_dir_down = 2'b10
  } tbc_dir_t;
endpackage : tbc_pkg

/* File: shared/tbc_tick_if.sv */
// carrier between the timer core and its tick source block
// assumes both ends run on ref_clk
`timescale 1ns/100ps
interface tbc_tick_if;
  tbc_pkg::tbc_sel_t sel; // chosen tick source
  logic tick; // one-cycle timer tick
  modport ctrl (output sel, input tick);
  modport src (input sel, output tick);
endinterface : tbc_tick_if

/* File: core/tbc_tick_select.sv */
// tick source of the timer: prescaler taps and a synchronised external pin
// assumes ext_pin is asynchronous to ref_clk and rst is asynchronous active high
`timescale 1ns/100ps
`include "tbc_cfg.svh"
module tbc_tick_select #(
  parameter int PRESCALE_W = `TBC_PRESCALE_W
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ext_pin,
  tbc_tick_if.src tk
);
  // the taps need the full divide-by-1024 range
  if (PRESCALE_W < `TBC_PRESCALE_W) begin : g_chk
    $error("tbc_tick_select: PRESCALE_W too small");
  end

  localparam logic [`TBC_TAPS*`TBC_PRESCALE_W-1:0] TAP_MASKS = `TBC_TAP_MASKS;

  logic [PRESCALE_W-1:0] pre_ff; // free-running prescaler
  logic sync1_ff; // first synchroniser stage, read only by sync2_ff
  logic sync2_ff; // second synchroniser stage
  logic last_ff; // previous synchronised level, for edge detect
  logic tick_ff; // registered tick
  logic [`TBC_TAPS-1:0] tap_hit; // one bit per divider tap
  logic rise; // external rising edge
  logic fall; // external falling edge
  logic nxt_tick;

  // one tap per divider: hit once every 2^k cycles when the low bits are all ones
  for (genvar i = 0; i < `TBC_TAPS; i++) begin : g_tap
    assign tap_hit[i] =
      (pre_ff[`TBC_PRESCALE_W-1:0] & TAP_MASKS[i*`TBC_PRESCALE_W +: `TBC_PRESCALE_W])
      == TAP_MASKS[i*`TBC_PRESCALE_W +: `TBC_PRESCALE_W];
  end

  assign rise = sync2_ff & ~last_ff;
  assign fall = ~sync2_ff & last_ff;

  // selection of the tick; code zero gives none at all
  assign nxt_tick = (tk.sel == `TBC_CS_DIV1) ? 1'b1 :
                    (tk.sel == `TBC_CS_DIV8) ? tap_hit[0] :
                    (tk.sel == `TBC_CS_DIV64) ? tap_hit[1] :
                    (tk.sel == `TBC_CS_DIV256) ? tap_hit[2] :
                    (tk.sel == `TBC_CS_DIV1024) ? tap_hit[3] :
                    (tk.sel == `TBC_CS_EXT_FALL) ? fall :
                    (tk.sel == `TBC_CS_EXT_RISE) ? rise :
                    1'b0;

  // prescaler, synchroniser and tick register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pre_ff <= '0;
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      last_ff <= 1'b0;
      tick_ff <= 1'b0;
    end else begin
      pre_ff <= pre_ff + {{(PRESCALE_W-1){1'b0}}, 1'b1};
      sync1_ff <= ext_pin;
      sync2_ff <= sync1_ff;
      last_ff <= sync2_ff;
      tick_ff <= nxt_tick;
    end
  end

  assign tk.tick = tick_ff;
endmodule : tbc_tick_select

/* File: core/tbc_timer16.sv */
// counter core of a 16-bit timer reached over an 8-bit register port
// assumes one clock ref_clk, asynchronous active-high rst, and a bus master that
// keeps strobes one cycle long, never both at once, and takes read data a cycle later
`timescale 1ns/100ps
`include "tbc_cfg.svh"
module tbc_timer16 #(
  parameter int PRESCALE_W = `TBC_PRESCALE_W
) (
  input wire logic ref_clk, // system clock, 40 MHz
  input wire logic rst, // asynchronous reset, active high
  input wire logic [3:0] bus_addr, // register offset
  input wire logic [7:0] bus_wdata, // write byte
  input wire logic bus_wr, // write strobe
  input wire logic bus_rd, // read strobe
  output logic [7:0] bus_rdata, // read byte, valid the cycle after bus_rd
  input wire logic ext_tick_pin, // external tick source, asynchronous
  output logic [15:0] count_value, // current count
  output logic at_top, // count equals the top of the sequence
  output logic at_bottom, // count equals zero
  output logic wrap_flag // sticky wrap flag, usable as interrupt request
);

  // stored state
  tbc_pkg::tbc_byte_t stage_ff; // shared staging byte for split accesses
  tbc_pkg::tbc_word_t count_ff; // the counter
  tbc_pkg::tbc_word_t match_a_ff; // match value A
  tbc_pkg::tbc_word_t match_b_ff; // match value B
  tbc_pkg::tbc_word_t snap_ff; // snapshot value, doubles as a top
  tbc_pkg::tbc_mode_t wave_mode_ff; // wave mode select, both halves
  tbc_pkg::tbc_sel_t sel_ff; // tick source select
  tbc_pkg::tbc_dir_t dir_ff; // count direction in dual-slope modes
  logic wrap_ff; // wrap flag
  tbc_pkg::tbc_byte_t rdata_ff; // registered read data

  // next values
  tbc_pkg::tbc_byte_t nxt_stage;
  tbc_pkg::tbc_word_t nxt_count;
  tbc_pkg::tbc_word_t nxt_match_a;
  tbc_pkg::tbc_word_t nxt_match_b;
  tbc_pkg::tbc_word_t nxt_snap;
  tbc_pkg::tbc_mode_t nxt_wave_mode;
  tbc_pkg::tbc_sel_t nxt_sel;
  tbc_pkg::tbc_dir_t nxt_dir;
  logic nxt_wrap;
  tbc_pkg::tbc_byte_t nxt_rdata;

  // tick source block, reached through the carrier interface
  tbc_tick_if tick_bus ();
  logic tick; // one-cycle timer tick

  assign tick_bus.sel = sel_ff;
  assign tick = tick_bus.tick;

  tbc_tick_select #(
    .PRESCALE_W (PRESCALE_W)
  ) u_tick (
    .ref_clk (ref_clk),
    .rst (rst),
    .ext_pin (ext_tick_pin),
    .tk (tick_bus.src)
  );

  // address decode
  logic sel_cnt_lo;
  logic sel_cnt_hi;
  logic sel_ma_lo;
  logic sel_ma_hi;
  logic sel_mb_lo;
  logic sel_mb_hi;
  logic sel_snap_lo;
  logic sel_snap_hi;
  logic sel_ctl1;
  logic sel_ctl2;
  logic sel_flags;

  assign sel_cnt_lo = bus_addr == `TBC_A_CNT_LO;
  assign sel_cnt_hi = bus_addr == `TBC_A_CNT_HI;
  assign sel_ma_lo = bus_addr == `TBC_A_MA_LO;
  assign sel_ma_hi = bus_addr == `TBC_A_MA_HI;
  assign sel_mb_lo = bus_addr == `TBC_A_MB_LO;
  assign sel_mb_hi = bus_addr == `TBC_A_MB_HI;
  assign sel_snap_lo = bus_addr == `TBC_A_SNAP_LO;
  assign sel_snap_hi = bus_addr == `TBC_A_SNAP_HI;
  assign sel_ctl1 = bus_addr == `TBC_A_CTL1;
  assign sel_ctl2 = bus_addr == `TBC_A_CTL2;
  assign sel_flags = bus_addr == `TBC_A_FLAGS;

  // qualified strobes
  logic wr_cnt_lo;
  logic wr_ma_lo;
  logic wr_mb_lo;
  logic wr_snap_lo;
  logic wr_any_hi; // any upper-byte location written
  logic rd_cnt_lo;
  logic rd_snap_lo;

  assign wr_cnt_lo = bus_wr & sel_cnt_lo;
  assign wr_ma_lo = bus_wr & sel_ma_lo;
  assign wr_mb_lo = bus_wr & sel_mb_lo;
  assign wr_snap_lo = bus_wr & sel_snap_lo;
  // the four upper locations all land in the one staging byte
  assign wr_any_hi = bus_wr & (sel_cnt_hi | sel_ma_hi | sel_mb_hi | sel_snap_hi);
  assign rd_cnt_lo = bus_rd & sel_cnt_lo;
  assign rd_snap_lo = bus_rd & sel_snap_lo;

  // wave mode decode
  logic mode_top_snap; // snapshot defines top
  logic mode_top_ma; // match A defines top
  logic mode_top_8; // fixed 8-bit top
  logic mode_top_9; // fixed 9-bit top
  logic mode_top_10; // fixed 10-bit top
  logic mode_dual; // up-down sequence
  logic mode_ctc; // clear at top, wrap flag at maximum
  tbc_pkg::tbc_word_t top_value; // highest value of the sequence

  assign mode_top_snap = (wave_mode_ff == 4'h8) | (wave_mode_ff == 4'ha) |
                         (wave_mode_ff == 4'hc) | (wave_mode_ff == 4'he);
  assign mode_top_ma = (wave_mode_ff == 4'h4) | (wave_mode_ff == 4'h9) |
                       (wave_mode_ff == 4'hb) | (wave_mode_ff == 4'hf);
  assign mode_top_8 = (wave_mode_ff == 4'h1) | (wave_mode_ff == 4'h5);
  assign mode_top_9 = (wave_mode_ff == 4'h2) | (wave_mode_ff == 4'h6);
  assign mode_top_10 = (wave_mode_ff == 4'h3) | (wave_mode_ff == 4'h7);
  assign mode_dual = (wave_mode_ff == 4'h1) | (wave_mode_ff == 4'h2) |
                     (wave_mode_ff == 4'h3) | (wave_mode_ff == 4'h8) |
                     (wave_mode_ff == 4'h9) | (wave_mode_ff == 4'ha) |
                     (wave_mode_ff == 4'hb);
  assign mode_ctc = (wave_mode_ff == 4'h4) | (wave_mode_ff == 4'hc);

  // normal mode and the unused code fall through to the full 16-bit range
  assign top_value = mode_top_snap ? snap_ff :
                     mode_top_ma ? match_a_ff :
                     mode_top_8 ? `TBC_TOP_8 :
                     mode_top_9 ? `TBC_TOP_9 :
                     mode_top_10 ? `TBC_TOP_10 :
                     `TBC_MAX;

  // count sequence
  logic cnt_is_top;
  logic cnt_is_bottom;
  logic cnt_is_max;
  logic turn_down; // dual slope reaching top while rising
  logic turn_up; // dual slope reaching bottom while falling
  tbc_pkg::tbc_word_t cnt_inc;
  tbc_pkg::tbc_word_t cnt_dec;
  tbc_pkg::tbc_word_t cnt_single; // next count in single-slope modes
  tbc_pkg::tbc_word_t cnt_dual; // next count in dual-slope modes
  tbc_pkg::tbc_word_t cnt_ticked; // next count when a tick arrives

  assign cnt_is_top = count_ff == top_value;
  assign cnt_is_bottom = count_ff == `TBC_BOTTOM;
  assign cnt_is_max = count_ff == `TBC_MAX;
  assign cnt_inc = count_ff + `TBC_STEP;
  assign cnt_dec = count_ff - `TBC_STEP;
  // a top lowered below the count turns it down at the next tick, never letting it run past
  assign turn_down = (dir_ff == tbc_pkg::tbc_dir_up) & (count_ff >= top_value);
  assign turn_up = (dir_ff == tbc_pkg::tbc_dir_down) & cnt_is_bottom;

  // single slope clears at top; with top at maximum the increment wraps to zero anyway
  assign cnt_single = cnt_is_top ? `TBC_BOTTOM : cnt_inc;
  assign cnt_dual = turn_down ? cnt_dec :
                    turn_up ? cnt_inc :
                    (dir_ff == tbc_pkg::tbc_dir_up) ? cnt_inc : cnt_dec;
  assign cnt_ticked = mode_dual ? cnt_dual : cnt_single;

  // wrap event: bottom turn in dual slope, maximum in clear-on-match, top otherwise
  logic wrap_evt;

  assign wrap_evt = tick & (mode_dual ? turn_up :
                            mode_ctc ? cnt_is_max : cnt_is_top);

  // counter next value; a software write outranks the tick in the same cycle
  assign nxt_count = wr_cnt_lo ? {stage_ff, bus_wdata} :
                     tick ? cnt_ticked :
                     count_ff;

  // direction only moves on ticks of dual-slope modes; single slope parks it up
  assign nxt_dir = ~mode_dual ? tbc_pkg::tbc_dir_up :
                   (tick & ~wr_cnt_lo & turn_down) ? tbc_pkg::tbc_dir_down :
                   (tick & ~wr_cnt_lo & turn_up) ? tbc_pkg::tbc_dir_up :
                   dir_ff;

  // staging byte: upper writes fill it, low reads of counter and snapshot refill it;
  // match reads leave it alone so a pending split write is not disturbed
  assign nxt_stage = wr_any_hi ? bus_wdata :
                     rd_cnt_lo ? count_ff[15:8] :
                     rd_snap_lo ? snap_ff[15:8] :
                     stage_ff;

  // word registers take the staging byte as upper half on each low write
  assign nxt_match_a = wr_ma_lo ? {stage_ff, bus_wdata} : match_a_ff;
  assign nxt_match_b = wr_mb_lo ? {stage_ff, bus_wdata} : match_b_ff;
  // snapshot writes are dropped unless the mode uses it as top
  assign nxt_snap = (wr_snap_lo & mode_top_snap) ? {stage_ff, bus_wdata} : snap_ff;

  // control registers; the wave mode halves sit in the two control bytes
  assign nxt_wave_mode = {(bus_wr & sel_ctl2) ? bus_wdata[`TBC_CTL2_WM_HI]
                                              : wave_mode_ff[3:2],
                          (bus_wr & sel_ctl1) ? bus_wdata[`TBC_CTL1_WM_LO]
                                              : wave_mode_ff[1:0]};
  assign nxt_sel = (bus_wr & sel_ctl2) ? bus_wdata[`TBC_CTL2_CS] : sel_ff;

  // wrap flag: writing one clears it, but a new event in the same cycle wins
  logic wrap_clr;

  assign wrap_clr = bus_wr & sel_flags & bus_wdata[`TBC_FLAG_WRAP];
  assign nxt_wrap = wrap_evt | (wrap_ff & ~wrap_clr);

  // read multiplexer; upper counter and snapshot bytes come from staging
  tbc_pkg::tbc_byte_t rd_mux;
  tbc_pkg::tbc_byte_t ctl1_view;
  tbc_pkg::tbc_byte_t ctl2_view;
  tbc_pkg::tbc_byte_t flags_view;

  assign ctl1_view = {6'h00, wave_mode_ff[1:0]};
  assign ctl2_view = {3'h0, wave_mode_ff[3:2], sel_ff};
  assign flags_view = {7'h00, wrap_ff};
  assign rd_mux = sel_cnt_lo ? count_ff[7:0] :
                  sel_cnt_hi ? stage_ff :
                  sel_ma_lo ? match_a_ff[7:0] :
                  sel_ma_hi ? match_a_ff[15:8] :
                  sel_mb_lo ? match_b_ff[7:0] :
                  sel_mb_hi ? match_b_ff[15:8] :
                  sel_snap_lo ? snap_ff[7:0] :
                  sel_snap_hi ? stage_ff :
                  sel_ctl1 ? ctl1_view :
                  sel_ctl2 ? ctl2_view :
                  sel_flags ? flags_view :
                  `TBC_RST_BYTE; // unmapped offsets read zero
  // read data stands only in the cycle after the strobe, zero otherwise
  assign nxt_rdata = bus_rd ? rd_mux : `TBC_RST_BYTE;

  // staging byte and counter; reset leaves the timer stopped at zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stage_ff <= `TBC_RST_BYTE;
      count_ff <= `TBC_RST_WORD;
      dir_ff <= tbc_pkg::tbc_dir_up;
    end else begin
      stage_ff <= nxt_stage;
      count_ff <= nxt_count;
      dir_ff <= nxt_dir;
    end
  end

  // word registers behind the staging byte
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      match_a_ff <= `TBC_RST_WORD;
      match_b_ff <= `TBC_RST_WORD;
      snap_ff <= `TBC_RST_WORD;
    end else begin
      match_a_ff <= nxt_match_a;
      match_b_ff <= nxt_match_b;
      snap_ff <= nxt_snap;
    end
  end

  // control, flag and read data
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wave_mode_ff <= `TBC_RST_MODE;
      sel_ff <= `TBC_RST_SEL;
      wrap_ff <= 1'b0;
      rdata_ff <= `TBC_RST_BYTE;
    end else begin
      wave_mode_ff <= nxt_wave_mode;
      sel_ff <= nxt_sel;
      wrap_ff <= nxt_wrap;
      rdata_ff <= nxt_rdata;
    end
  end

  // outputs; the indications are decoded from the registered count
  assign bus_rdata = rdata_ff;
  assign count_value = count_ff;
  assign at_top = cnt_is_top;
  assign at_bottom = cnt_is_bottom;
  assign wrap_flag = wrap_ff;

endmodule : tbc_timer16

/* File: test/tbc_timer16_chk.sv */
// port assertions for the byte-access timer core, bound into every tbc_timer16
// assumes a bus master with one-cycle strobes, never both high at once
`timescale 1ns/100ps
`include "tbc_cfg.svh"
module tbc_timer16_chk #(
  parameter int PRESCALE_W = `TBC_PRESCALE_W
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rdata,
  input wire logic ext_tick_pin,
  input wire logic [15:0] count_value,
  input wire logic at_top,
  input wire logic at_bottom,
  input wire logic wrap_flag
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [2:0] sel_ff; // shadow of the tick select
  logic [3:0] mode_ff; // shadow of the wave mode
  logic [15:0] cnt_q_ff; // count one cycle back
  logic [15:0] cnt_qq_ff; // count two cycles back
  wire logic wr_ctl1 = bus_wr && bus_addr == `TBC_A_CTL1; // first control written
  wire logic wr_ctl2 = bus_wr && bus_addr == `TBC_A_CTL2; // second control written
  wire logic wr_hi = bus_wr && bus_addr == `TBC_A_CNT_HI; // staging written
  wire logic wr_lo = bus_wr && bus_addr == `TBC_A_CNT_LO; // counter word loaded
  wire logic rd_lo = bus_rd && bus_addr == `TBC_A_CNT_LO; // counter low read
  wire logic rd_hi = bus_rd && bus_addr == `TBC_A_CNT_HI; // staging read
  // flag clear by writing one; set still wins in the same cycle
  wire logic clr_wrap = bus_wr && bus_addr == `TBC_A_FLAGS && bus_wdata[`TBC_FLAG_WRAP];
  // plain up counting: mode 0, every-clock ticks, no write this cycle
  wire logic run_up = sel_ff == `TBC_CS_DIV1 && mode_ff == `TBC_RST_MODE && !bus_wr;
  // shadow the control fields as software writes them
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sel_ff <= `TBC_RST_SEL;
      mode_ff <= `TBC_RST_MODE;
    end else if (wr_ctl1) begin
      mode_ff[1:0] <= bus_wdata[`TBC_CTL1_WM_LO];
    end else if (wr_ctl2) begin
      mode_ff[3:2] <= bus_wdata[`TBC_CTL2_WM_HI];
      sel_ff <= bus_wdata[`TBC_CTL2_CS];
    end
  end
  // count history; needs no reset since checks are off in reset
  always_ff @(posedge ref_clk) begin
    cnt_q_ff <= count_value;
    cnt_qq_ff <= cnt_q_ff;
  end
  low_write_a: assert property ((wr_hi ##1 wr_lo) |=>
    count_value == {$past(bus_wdata, 2), $past(bus_wdata)})
    else $error("counter word not loaded from staging and low byte");
  low_read_a: assert property (rd_lo |=> bus_rdata == cnt_q_ff[7:0])
    else $error("counter low byte read wrong");
  pair_read_a: assert property ((rd_lo ##1 rd_hi) |=> bus_rdata == cnt_qq_ff[15:8])
    else $error("staging did not hold upper byte from low read");
  stop_hold_a: assert property (
    (sel_ff == `TBC_CS_NONE && $past(sel_ff) == `TBC_CS_NONE && !bus_wr) |=> $stable(count_value))
    else $error("counter moved with no tick source");
  count_up_a: assert property ((run_up && $past(sel_ff) == `TBC_CS_DIV1) |=>
    count_value == cnt_q_ff + `TBC_STEP)
    else $error("counter did not step by one");
  bottom_flag_a: assert property (at_bottom == (count_value == `TBC_BOTTOM))
    else $error("bottom indication wrong");
  top_flag_a: assert property (mode_ff == `TBC_RST_MODE |->
    at_top == (count_value == `TBC_MAX))
    else $error("top indication wrong in mode 0");
  wrap_set_a: assert property (
    (run_up && $past(sel_ff) == `TBC_CS_DIV1 && count_value == `TBC_MAX) |=> wrap_flag)
    else $error("wrap flag not set at maximum");
  wrap_hold_a: assert property ((wrap_flag && !clr_wrap) |=> wrap_flag)
    else $error("wrap flag dropped without a clear");
endmodule : tbc_timer16_chk

bind tbc_timer16 tbc_timer16_chk #(.PRESCALE_W(PRESCALE_W)) u_chk (
  .ref_clk(ref_clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
  .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .ext_tick_pin(ext_tick_pin),
  .count_value(count_value), .at_top(at_top), .at_bottom(at_bottom), .wrap_flag(wrap_flag));

/* File: test/tbc_cpu_model.sv */
// processor side of the register port: byte reads and writes, 16-bit pairs
// assumes one software thread, so no interrupt code can split a pair
`timescale 1ns/100ps
module tbc_cpu_model (
  input wire logic ref_clk,
  output logic [3:0] bus_addr,
  output logic [7:0] bus_wdata,
  output logic bus_wr,
  output logic bus_rd,
  input wire logic [7:0] bus_rdata
);
  // bus quiet at time zero
  initial begin
    bus_addr = 4'h0;
    bus_wdata = 8'h00;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
  end
  // one write cycle; strobe stays up so another access may follow at once
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    bus_rd <= 1'b0;
    @(posedge ref_clk);
  endtask : wr
  // release; released lines flip so stale values never look valid
  task automatic idle(input int n);
    bus_wr <= 1'b0;
    bus_rd <= 1'b0;
    bus_addr <= ~bus_addr;
    bus_wdata <= ~bus_wdata;
    repeat (n) @(posedge ref_clk);
  endtask : idle
  // one read; data taken at the edge after the strobe edge
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    bus_addr <= a;
    bus_wr <= 1'b0;
    bus_rd <= 1'b1;
    @(posedge ref_clk);
    idle(1);
    d = bus_rdata;
  endtask : rd
  // upper byte first, lower byte triggers the load; never interrupted
  task automatic wr16(input logic [3:0] a, input logic [15:0] w);
    wr(a + 4'h1, w[15:8]);
    wr(a, w[7:0]);
  endtask : wr16
  // lower byte first, upper read back to back; never interrupted
  task automatic rd16(input logic [3:0] a, output logic [15:0] w);
    bus_addr <= a;
    bus_rd <= 1'b1;
    bus_wr <= 1'b0;
    @(posedge ref_clk);
    bus_addr <= a + 4'h1;
    @(posedge ref_clk);
    w[7:0] = bus_rdata;
    idle(1);
    w[15:8] = bus_rdata;
  endtask : rd16
endmodule : tbc_cpu_model

/* File: test/testbench.sv */
// self-checking bench for the timer core: byte access, staging and counting
// assumes the design, the checker and the processor model are compiled first
`timescale 1ns/100ps
`include "tbc_cfg.svh"
module testbench;
  logic ref_clk;
  logic rst;
  logic ext_tick_pin; // external tick source
  logic [3:0] bus_addr;
  logic [7:0] bus_wdata;
  logic bus_wr;
  logic bus_rd;
  logic [7:0] bus_rdata;
  logic [15:0] count_value;
  logic at_top;
  logic at_bottom;
  logic wrap_flag;
  int fail_count;
  int checks;
  int div [4] = '{8, 64, 256, 1024}; // prescaler ratios of codes 2 to 5
  logic [15:0] ext_exp [4] = '{16'h0001, 16'h0001, 16'h0001, 16'h0002}; // pin edge counts
  initial ref_clk = 1'b0;
  always #12.5 ref_clk = ~ref_clk;
  tbc_timer16 u_dut (.ref_clk(ref_clk), .rst(rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .ext_tick_pin(ext_tick_pin), .count_value(count_value), .at_top(at_top),
    .at_bottom(at_bottom), .wrap_flag(wrap_flag));
  tbc_cpu_model u_cpu (.ref_clk(ref_clk), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));
  // compare and count; unknowns never match
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic stop_test();
    if (fail_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test
  task automatic r8(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_cpu.rd(a, d);
    chk({8'h00, d}, {8'h00, exp});
  endtask : r8
  task automatic r16(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] w;
    u_cpu.rd16(a, w);
    chk(w, exp);
  endtask : r16
  // wait for a count value; running out of cycles ends the run as a failure
  task automatic wait_cnt(input logic [15:0] v, input int lim);
    int i;
    for (i = 0; i < lim && count_value !== v; i++) begin
      @(posedge ref_clk);
    end
    if (i == lim) begin
      fail_count++;
      stop_test();
    end
  endtask : wait_cnt
  // main sequence; every write is followed by another access or an idle
  initial begin
    rst = 1'b1;
    ext_tick_pin = 1'b0;
    fail_count = 0;
    checks = 0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    chk(count_value, `TBC_RST_WORD);
    chk({15'h0000, at_bottom}, 16'h0001);
    r8(`TBC_A_CTL2, 8'h00);
    r8(`TBC_A_CNT_HI, 8'h00);
    u_cpu.wr16(`TBC_A_CNT_LO, 16'h01ff);
    u_cpu.idle(20);
    chk(count_value, 16'h01ff);
    r16(`TBC_A_CNT_LO, 16'h01ff);
    // one upper byte serves two lower writes, then staging changes
    u_cpu.wr(`TBC_A_CNT_HI, 8'h12);
    u_cpu.wr(`TBC_A_CNT_LO, 8'h34);
    u_cpu.wr(`TBC_A_MA_LO, 8'h56);
    u_cpu.wr(`TBC_A_CNT_HI, 8'hab);
    u_cpu.idle(1);
    chk(count_value, 16'h1234);
    r8(`TBC_A_MA_HI, 8'h12);
    r8(`TBC_A_MA_LO, 8'h56);
    r8(`TBC_A_CNT_HI, 8'hab);
    u_cpu.wr16(`TBC_A_MB_LO, 16'h5aa5);
    r16(`TBC_A_MB_LO, 16'h5aa5);
    r8(`TBC_A_CNT_HI, 8'h5a);
    u_cpu.wr(4'hc, 8'hff);
    r8(4'hc, 8'h00);
    // snapshot takes writes only once mode 12 makes it the top
    u_cpu.wr16(`TBC_A_SNAP_LO, 16'h0777);
    r16(`TBC_A_SNAP_LO, 16'h0000);
    u_cpu.wr(`TBC_A_CTL2, 8'h18);
    u_cpu.wr16(`TBC_A_SNAP_LO, 16'h0005);
    r16(`TBC_A_SNAP_LO, 16'h0005);
    u_cpu.wr16(`TBC_A_CNT_LO, 16'h0000);
    u_cpu.wr(`TBC_A_CTL2, 8'h19);
    u_cpu.idle(1);
    wait_cnt(16'h0005, 20);
    chk({15'h0000, at_top}, 16'h0001);
    @(posedge ref_clk);
    chk(count_value, 16'h0000);
    chk({15'h0000, wrap_flag}, 16'h0000);
    // mode 0 through the maximum, flag clear, then a write beats a tick
    u_cpu.wr(`TBC_A_CTL2, 8'h00);
    u_cpu.wr16(`TBC_A_CNT_LO, 16'hfff0);
    u_cpu.wr(`TBC_A_CTL2, 8'h01);
    u_cpu.idle(1);
    wait_cnt(16'hffff, 40);
    chk({15'h0000, at_top}, 16'h0001);
    @(posedge ref_clk);
    chk({15'h0000, at_bottom}, 16'h0001);
    chk({15'h0000, wrap_flag}, 16'h0001);
    u_cpu.wr(`TBC_A_FLAGS, 8'h01);
    u_cpu.idle(1);
    chk({15'h0000, wrap_flag}, 16'h0000);
    u_cpu.wr16(`TBC_A_CNT_LO, 16'h4000);
    u_cpu.idle(1);
    chk(count_value, 16'h4000);
    @(posedge ref_clk);
    chk(count_value, 16'h4001);
    // dual slope mode 1: up to 0x00ff, down to zero, flag at the turn
    u_cpu.wr(`TBC_A_CTL2, 8'h00);
    u_cpu.wr(`TBC_A_CTL1, 8'h01);
    u_cpu.wr16(`TBC_A_CNT_LO, 16'h00fd);
    u_cpu.wr(`TBC_A_CTL2, 8'h01);
    u_cpu.idle(1);
    wait_cnt(16'h00ff, 20);
    chk({15'h0000, at_top}, 16'h0001);
    @(posedge ref_clk);
    chk(count_value, 16'h00fe);
    wait_cnt(16'h0000, 300);
    @(posedge ref_clk);
    chk(count_value, 16'h0001);
    chk({15'h0000, wrap_flag}, 16'h0001);
    // prescaled codes: twelve divider periods give eleven to thirteen steps
    u_cpu.wr(`TBC_A_CTL1, 8'h00);
    for (int k = 0; k < 4; k++) begin
      // stop first: the registered tick of the old code still lands one cycle late
      u_cpu.wr(`TBC_A_CTL2, 8'h00);
      u_cpu.wr16(`TBC_A_CNT_LO, 16'h0000);
      u_cpu.wr(`TBC_A_CTL2, 8'(k + 2));
      u_cpu.idle(12 * div[k]);
      chk({15'h0000, count_value >= 16'h000b && count_value <= 16'h000d}, 16'h0001);
    end
    // external pin: code 7 counts rising edges, code 6 falling edges
    u_cpu.wr(`TBC_A_CTL2, 8'h07);
    u_cpu.wr16(`TBC_A_CNT_LO, 16'h0000);
    u_cpu.idle(8);
    for (int k = 0; k < 4; k++) begin
      if (k == 2) begin
        u_cpu.wr(`TBC_A_CTL2, 8'h06);
        u_cpu.idle(8);
      end
      ext_tick_pin <= ~ext_tick_pin;
      repeat (8) @(posedge ref_clk);
      chk(count_value, ext_exp[k]);
    end
    // reset in mid-run: staging, count and select all go back to zero
    u_cpu.wr(`TBC_A_CNT_HI, 8'h77);
    u_cpu.idle(1);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    chk(count_value, `TBC_RST_WORD);
    r8(`TBC_A_CNT_HI, 8'h00);
    r8(`TBC_A_CTL2, 8'h00);
    stop_test();
  end
endmodule : testbench
